// File: rtl/port_alt_function_select.sv
// port 0 and port 3 function selector with debug pin release, APB slave
//
// Behaviour
// - after reset, port 0 bit 5 serves as debug unit reset input, not as port or irq 2.
// - pull-down on the debug reset pin is on after reset and off once the enable clears.
// - in alternate mode the port output data is ignored.
// - alternate function chosen by mode bit 1 plus select and extended select bits.
// - mode bit 0 keeps a port, mode bit 1 gives the pin to its alternate function.
//
// Design decisions made here: register access over APB and the address map.
`include "pin_mux_regs.svh"
module port_alt_function_select #(
  parameter int PORT_W = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PORT_W-1:0] port0_pin_in,
  output logic [PORT_W-1:0] port0_pin_out,
  output logic [PORT_W-1:0] port0_pin_oe,
  input wire logic [PORT_W-1:0] port3_pin_in,
  output logic [PORT_W-1:0] port3_pin_out,
  output logic [PORT_W-1:0] port3_pin_oe,
  input wire logic [4*PORT_W-1:0] port0_alt_out,
  input wire logic [4*PORT_W-1:0] port0_alt_oe,
  input wire logic [4*PORT_W-1:0] port3_alt_out,
  input wire logic [4*PORT_W-1:0] port3_alt_oe,
  input wire logic irq7_rising_enable,
  input wire logic irq7_falling_enable,
  input wire logic irq8_rising_enable,
  input wire logic irq8_falling_enable,
  input wire logic uart0_receive_enable,
  input wire logic uart2_receive_enable,
  output logic debug_unit_reset_in,
  output logic debug_pulldown_on,
  output logic ext_irq2_in,
  output logic ext_irq7_in,
  output logic ext_irq8_in,
  output logic uart0_receive_in,
  output logic uart2_receive_in,
  output logic share_conflict
);
  logic debug_pins_enable_bit_q, debug_pins_enable_bit_d;
  logic [PORT_W-1:0] p0_data_q, p0_data_d, p0_dir_q, p0_dir_d;
  logic [PORT_W-1:0] p0_mode_q, p0_mode_d, p0_fsel_q, p0_fsel_d, p0_fselx_q, p0_fselx_d;
  logic [PORT_W-1:0] p3_data_q, p3_data_d, p3_dir_q, p3_dir_d;
  logic [PORT_W-1:0] p3_mode_q, p3_mode_d, p3_fsel_q, p3_fsel_d, p3_fselx_q, p3_fselx_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic wr_en, rd_en, hit;
  logic [31:0] rd_val;
  logic [PORT_W-1:0] p0_force_in;
  logic dbg_d, pd_d, irq2_d, irq7_d, irq8_d, rx0_d, rx2_d, conflict_d;
  logic [31:0] stat;

  // zero wait state: setup cycle then one access cycle
  // a write lands only at the access edge, where the master sees pready high
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  always_comb
  begin
    stat = 32'h0000_0000;
    stat[0] = debug_pins_enable_bit_q;
    stat[1] = share_conflict;
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `PM_OFS_DEBUG_CTRL: rd_val[`PM_BIT_DEBUG_EN] = debug_pins_enable_bit_q;
      `PM_OFS_P0_DATA: rd_val[PORT_W-1:0] = p0_data_q;
      `PM_OFS_P0_DIR: rd_val[PORT_W-1:0] = p0_dir_q;
      `PM_OFS_P0_MODE: rd_val[PORT_W-1:0] = p0_mode_q;
      `PM_OFS_P0_FSEL: rd_val[PORT_W-1:0] = p0_fsel_q;
      `PM_OFS_P0_FSELX: rd_val[PORT_W-1:0] = p0_fselx_q;
      `PM_OFS_P3_DATA: rd_val[PORT_W-1:0] = p3_data_q;
      `PM_OFS_P3_DIR: rd_val[PORT_W-1:0] = p3_dir_q;
      `PM_OFS_P3_MODE: rd_val[PORT_W-1:0] = p3_mode_q;
      `PM_OFS_P3_FSEL: rd_val[PORT_W-1:0] = p3_fsel_q;
      `PM_OFS_P3_FSELX: rd_val[PORT_W-1:0] = p3_fselx_q;
      `PM_OFS_P0_LEVEL: rd_val[PORT_W-1:0] = port0_pin_in;
      `PM_OFS_P3_LEVEL: rd_val[PORT_W-1:0] = port3_pin_in;
      `PM_OFS_STATUS: rd_val = stat;
      default: hit = 1'b0;
    endcase
  end

  always_comb
  begin
    debug_pins_enable_bit_d = debug_pins_enable_bit_q;
    p0_data_d = p0_data_q;
    p0_dir_d = p0_dir_q;
    p0_mode_d = p0_mode_q;
    p0_fsel_d = p0_fsel_q;
    p0_fselx_d = p0_fselx_q;
    p3_data_d = p3_data_q;
    p3_dir_d = p3_dir_q;
    p3_mode_d = p3_mode_q;
    p3_fsel_d = p3_fsel_q;
    p3_fselx_d = p3_fselx_q;
    pready_d = psel & ~penable;
    pslverr_d = psel & ~penable & ~hit;
    prdata_d = (rd_en & hit) ? rd_val : 32'h0000_0000;
    if (wr_en)
    begin
      unique case (paddr)
        // the enable only clears; it is restored by reset alone
        `PM_OFS_DEBUG_CTRL: debug_pins_enable_bit_d =
          debug_pins_enable_bit_q & pwdata[`PM_BIT_DEBUG_EN];
        `PM_OFS_P0_DATA: p0_data_d = pwdata[PORT_W-1:0];
        `PM_OFS_P0_DIR: p0_dir_d = pwdata[PORT_W-1:0];
        `PM_OFS_P0_MODE: p0_mode_d = pwdata[PORT_W-1:0];
        `PM_OFS_P0_FSEL: p0_fsel_d = pwdata[PORT_W-1:0];
        `PM_OFS_P0_FSELX: p0_fselx_d = pwdata[PORT_W-1:0];
        `PM_OFS_P3_DATA: p3_data_d = pwdata[PORT_W-1:0];
        `PM_OFS_P3_DIR: p3_dir_d = pwdata[PORT_W-1:0];
        `PM_OFS_P3_MODE: p3_mode_d = pwdata[PORT_W-1:0];
        `PM_OFS_P3_FSEL: p3_fsel_d = pwdata[PORT_W-1:0];
        `PM_OFS_P3_FSELX: p3_fselx_d = pwdata[PORT_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      debug_pins_enable_bit_q <= `PM_RST_DEBUG_CTRL;
      p0_data_q <= `PM_RST_ZERO;
      p0_dir_q <= `PM_RST_DIR;
      p0_mode_q <= `PM_RST_ZERO;
      p0_fsel_q <= `PM_RST_ZERO;
      p0_fselx_q <= `PM_RST_ZERO;
      p3_data_q <= `PM_RST_ZERO;
      p3_dir_q <= `PM_RST_DIR;
      p3_mode_q <= `PM_RST_ZERO;
      p3_fsel_q <= `PM_RST_ZERO;
      p3_fselx_q <= `PM_RST_ZERO;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      debug_pins_enable_bit_q <= debug_pins_enable_bit_d;
      p0_data_q <= p0_data_d;
      p0_dir_q <= p0_dir_d;
      p0_mode_q <= p0_mode_d;
      p0_fsel_q <= p0_fsel_d;
      p0_fselx_q <= p0_fselx_d;
      p3_data_q <= p3_data_d;
      p3_dir_q <= p3_dir_d;
      p3_mode_q <= p3_mode_d;
      p3_fsel_q <= p3_fsel_d;
      p3_fselx_q <= p3_fselx_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // debug reset pin is held as input while the debug unit owns it
  always_comb
  begin
    p0_force_in = '0;
    p0_force_in[`PM_BIT_DEBUG_RST] = debug_pins_enable_bit_q;
  end

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++)
    begin : g_pin
      pin_cell u_p0 (
        .mclk(mclk),
        .reset(reset),
        .mode_bit(p0_mode_q[gi]),
        .dir_bit(p0_dir_q[gi]),
        .data_bit(p0_data_q[gi]),
        .fsel({p0_fselx_q[gi], p0_fsel_q[gi]}),
        .alt_out(port0_alt_out[4*gi +: 4]),
        .alt_oe(port0_alt_oe[4*gi +: 4]),
        .force_in(p0_force_in[gi]),
        .pin_out(port0_pin_out[gi]),
        .pin_oe(port0_pin_oe[gi])
      );
      pin_cell u_p3 (
        .mclk(mclk),
        .reset(reset),
        .mode_bit(p3_mode_q[gi]),
        .dir_bit(p3_dir_q[gi]),
        .data_bit(p3_data_q[gi]),
        .fsel({p3_fselx_q[gi], p3_fsel_q[gi]}),
        .alt_out(port3_alt_out[4*gi +: 4]),
        .alt_oe(port3_alt_oe[4*gi +: 4]),
        .force_in(1'b0),
        .pin_out(port3_pin_out[gi]),
        .pin_oe(port3_pin_oe[gi])
      );
    end
  endgenerate

  always_comb
  begin
    dbg_d = debug_pins_enable_bit_q & port0_pin_in[`PM_BIT_DEBUG_RST];
    pd_d = debug_pins_enable_bit_q;
    // irq 2 only reaches the controller once debug has let go
    irq2_d = ~debug_pins_enable_bit_q & p0_mode_q[`PM_BIT_DEBUG_RST]
             & port0_pin_in[`PM_BIT_DEBUG_RST];
    // shared receive pins feed both users; software keeps one idle
    irq7_d = p3_mode_q[`PM_BIT_IRQ7] & port3_pin_in[`PM_BIT_IRQ7];
    rx0_d = ~p3_mode_q[`PM_BIT_IRQ7] | port3_pin_in[`PM_BIT_IRQ7];
    irq8_d = p3_mode_q[`PM_BIT_IRQ8] & port3_pin_in[`PM_BIT_IRQ8];
    rx2_d = ~p3_mode_q[`PM_BIT_IRQ8] | port3_pin_in[`PM_BIT_IRQ8];
    conflict_d = (uart0_receive_enable & (irq7_rising_enable | irq7_falling_enable))
               | (uart2_receive_enable & (irq8_rising_enable | irq8_falling_enable));
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      debug_unit_reset_in <= 1'b0;
      debug_pulldown_on <= 1'b1;
      ext_irq2_in <= 1'b0;
      ext_irq7_in <= 1'b0;
      ext_irq8_in <= 1'b0;
      uart0_receive_in <= 1'b1;
      uart2_receive_in <= 1'b1;
      share_conflict <= 1'b0;
    end
    else
    begin
      debug_unit_reset_in <= dbg_d;
      debug_pulldown_on <= pd_d;
      ext_irq2_in <= irq2_d;
      ext_irq7_in <= irq7_d;
      ext_irq8_in <= irq8_d;
      uart0_receive_in <= rx0_d;
      uart2_receive_in <= rx2_d;
      share_conflict <= conflict_d;
    end
  end
endmodule

// File: rtl/pin_mux_regs.svh
// register offsets, field positions and reset values of the pin function selector
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH
`define PM_OFS_DEBUG_CTRL 12'h000
`define PM_OFS_P0_DATA 12'h010
`define PM_OFS_P0_DIR 12'h014
`define PM_OFS_P0_MODE 12'h018
`define PM_OFS_P0_FSEL 12'h01C
`define PM_OFS_P0_FSELX 12'h020
`define PM_OFS_P3_DATA 12'h030
`define PM_OFS_P3_DIR 12'h034
`define PM_OFS_P3_MODE 12'h038
`define PM_OFS_P3_FSEL 12'h03C
`define PM_OFS_P3_FSELX 12'h040
`define PM_OFS_P0_LEVEL 12'h050
`define PM_OFS_P3_LEVEL 12'h054
`define PM_OFS_STATUS 12'h060
`define PM_BIT_DEBUG_EN 0
`define PM_BIT_DEBUG_RST 5
`define PM_BIT_IRQ7 1
`define PM_BIT_IRQ8 9
`define PM_RST_DEBUG_CTRL 1'b1
`define PM_RST_DIR 16'hFFFF
`define PM_RST_ZERO 16'h0000
`endif

// File: rtl/pin_mux_pkg.sv
// types shared by the pin function selector
package pin_mux_pkg;
  typedef enum logic [1:0] {
    fn_sel_00 = 2'h0,
    fn_sel_01 = 2'h1,
    fn_sel_10 = 2'h2,
    fn_sel_11 = 2'h3
  } fn_sel_t;
endpackage

// File: rtl/pin_cell.sv
// one pin: chooses port or alternate function for driver and enable
`include "pin_mux_regs.svh"
module pin_cell (
  input wire logic mclk,
  input wire logic reset,
  input wire logic mode_bit,
  input wire logic dir_bit,
  input wire logic data_bit,
  input wire logic [1:0] fsel,
  input wire logic [3:0] alt_out,
  input wire logic [3:0] alt_oe,
  input wire logic force_in,
  output logic pin_out,
  output logic pin_oe
);
  logic out_d;
  logic oe_d;
  always_comb
  begin
    out_d = data_bit;
    oe_d = ~dir_bit;
    if (force_in)
    begin
      out_d = 1'b0;
      oe_d = 1'b0;
    end
    else if (mode_bit)
    begin
      // port data ignored in alternate mode
      unique case (pin_mux_pkg::fn_sel_t'(fsel))
        pin_mux_pkg::fn_sel_00:
        begin
          out_d = alt_out[0];
          oe_d = alt_oe[0];
        end
        pin_mux_pkg::fn_sel_01:
        begin
          out_d = alt_out[1];
          oe_d = alt_oe[1];
        end
        pin_mux_pkg::fn_sel_10:
        begin
          out_d = alt_out[2];
          oe_d = alt_oe[2];
        end
        pin_mux_pkg::fn_sel_11:
        begin
          out_d = alt_out[3];
          oe_d = alt_oe[3];
        end
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      pin_out <= out_d;
      pin_oe <= oe_d;
    end
  end
endmodule

// File: verification/pin_mux_sva.sv
// port-level assertions of the pin function selector
`include "pin_mux_regs.svh"
module pin_mux_sva #(
  parameter int PORT_W = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [PORT_W-1:0] port0_pin_in,
  input wire logic [PORT_W-1:0] port0_pin_out,
  input wire logic [PORT_W-1:0] port0_pin_oe,
  input wire logic [PORT_W-1:0] port3_pin_in,
  input wire logic irq7_rising_enable,
  input wire logic irq7_falling_enable,
  input wire logic uart0_receive_enable,
  input wire logic debug_unit_reset_in,
  input wire logic debug_pulldown_on,
  input wire logic ext_irq2_in,
  input wire logic ext_irq7_in,
  input wire logic ext_irq8_in,
  input wire logic uart0_receive_in,
  input wire logic uart2_receive_in,
  input wire logic share_conflict
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic clr;
  assign clr = psel && penable && pwrite && paddr == `PM_OFS_DEBUG_CTRL && !pwdata[0];
  property p_pin5_held; debug_pulldown_on |-> !port0_pin_oe[5] && !port0_pin_out[5]; endproperty
  a_pin5_held:
    assert property (p_pin5_held) else $error("pin5 driven while debug owns it");
  property p_irq2_off; debug_pulldown_on |-> !ext_irq2_in; endproperty
  a_irq2_off:
    assert property (p_irq2_off) else $error("irq2 live while debug owns pin5");
  property p_dbg_lvl;
    debug_pulldown_on && $past(debug_pulldown_on) && !$past(reset)
      |-> debug_unit_reset_in == $past(port0_pin_in[5]);
  endproperty
  a_dbg_lvl:
    assert property (p_dbg_lvl) else $error("debug reset input not following pin5");
  property p_pd_fall; $fell(debug_pulldown_on) |-> $past(clr) || $past(clr, 2) || $past(clr, 3);
  endproperty
  a_pd_fall:
    assert property (p_pd_fall) else $error("pull-down dropped without a clear");
  property p_pd_rise; !$past(reset) |-> !$rose(debug_pulldown_on); endproperty
  a_pd_rise:
    assert property (p_pd_rise) else $error("pull-down came back without reset");
  property p_irq7_lvl; ext_irq7_in |-> $past(port3_pin_in[1]); endproperty
  a_irq7_lvl:
    assert property (p_irq7_lvl) else $error("irq7 high with pin low");
  property p_rx0_lvl; !uart0_receive_in |-> !$past(port3_pin_in[1]); endproperty
  a_rx0_lvl:
    assert property (p_rx0_lvl) else $error("uart0 receive low with pin high");
  property p_rx2_pair; ext_irq8_in != uart2_receive_in |-> uart2_receive_in && !ext_irq8_in;
  endproperty
  a_rx2_pair:
    assert property (p_rx2_pair) else $error("shared pin9 inputs disagree");
  property p_conf;
    !$past(reset) && $past(uart0_receive_enable && (irq7_rising_enable || irq7_falling_enable))
      |-> share_conflict;
  endproperty
  a_conf:
    assert property (p_conf) else $error("conflict not flagged");
endmodule

// File: verification/board_model.sv
// board pins and peripheral sources around the pin function selector
module board_model (
  input wire logic debug_pulldown_on,
  input wire logic [15:0] lvl0,
  input wire logic [15:0] lvl3,
  input wire logic [15:0] out0,
  input wire logic [15:0] oe0,
  input wire logic [15:0] out3,
  input wire logic [15:0] oe3,
  output logic [15:0] in0,
  output logic [15:0] in3,
  output logic [63:0] alt_out,
  output logic [63:0] alt_oe
);
  // pin5 kept low while debug owns it, a high level there may hang the cpu
  assign in0 = (out0 & oe0) | (lvl0 & ~oe0 & (debug_pulldown_on ? 16'hFFDF : 16'hFFFF));
  assign in3 = (out3 & oe3) | (lvl3 & ~oe3);
  assign alt_out = {16{4'h6}};
  assign alt_oe = {16{4'hA}};
endmodule

// File: verification/tb_top.sv
// testbench of the pin function selector
`include "pin_mux_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] lvl0 = 16'h0, lvl3 = 16'h0, in0, in3, out0, oe0, out3, oe3;
  logic [63:0] alt_out, alt_oe;
  logic [5:0] en = 6'h00;
  logic dbg, pd, irq2, irq7, irq8, rx0, rx2, conf;
  int error_cnt = 0, n_tests = 0;
  always #10 mclk = ~mclk;
  port_alt_function_select i_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port0_pin_in(in0), .port0_pin_out(out0), .port0_pin_oe(oe0),
    .port3_pin_in(in3), .port3_pin_out(out3), .port3_pin_oe(oe3), .port0_alt_out(alt_out),
    .port0_alt_oe(alt_oe), .port3_alt_out(alt_out), .port3_alt_oe(alt_oe),
    .irq7_rising_enable(en[0]), .irq7_falling_enable(en[1]), .irq8_rising_enable(en[2]),
    .irq8_falling_enable(en[3]), .uart0_receive_enable(en[4]), .uart2_receive_enable(en[5]),
    .debug_unit_reset_in(dbg), .debug_pulldown_on(pd), .ext_irq2_in(irq2), .ext_irq7_in(irq7),
    .ext_irq8_in(irq8), .uart0_receive_in(rx0), .uart2_receive_in(rx2), .share_conflict(conf));
  board_model i_board (.debug_pulldown_on(pd), .lvl0(lvl0), .lvl3(lvl3), .out0(out0),
    .oe0(oe0), .out3(out3), .oe3(oe3), .in0(in0), .in3(in3), .alt_out(alt_out), .alt_oe(alt_oe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no wait limit here: a missing pready is caught by the watchdog
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // output lag is at most two edges, three leaves margin
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic t_reset;
    apb(0, `PM_OFS_STATUS, 0);
    check(rd[0], 1);
    apb(0, `PM_OFS_P0_DIR, 0);
    check(rd, 32'h0000FFFF);
    apb(0, `PM_OFS_P0_MODE, 0);
    check(rd, 0);
    apb(0, 12'h0FC, 0);
    check(err, 1);
    check(rd, 0);
    settle;
    check({pd, dbg, oe0[5], irq2}, 4'b1000);
    $display("test reset done");
  endtask
  task automatic t_port;
    apb(1, `PM_OFS_P0_DATA, 32'h1);
    apb(1, `PM_OFS_P0_DIR, 32'hFFFE);
    settle;
    check({out0[0], oe0[0]}, 2'b11);
    apb(1, `PM_OFS_P0_MODE, 32'h1);
    for (int c = 0; c < 4; c++)
    begin
      apb(1, `PM_OFS_P0_FSEL, c & 1);
      apb(1, `PM_OFS_P0_FSELX, c >> 1);
      settle;
      check(out0[0], (4'h6 >> c) & 4'h1);
      check(oe0[0], (4'hA >> c) & 4'h1);
    end
    $display("test port done");
  endtask
  task automatic t_debug;
    apb(1, `PM_OFS_DEBUG_CTRL, 0);
    apb(1, `PM_OFS_DEBUG_CTRL, 1);
    apb(0, `PM_OFS_STATUS, 0);
    check(rd[0], 0);
    apb(1, `PM_OFS_P0_MODE, 32'h21);
    lvl0 <= 16'h0020;
    settle;
    check({pd, dbg, irq2}, 3'b001);
    $display("test debug done");
  endtask
  task automatic t_share;
    apb(1, `PM_OFS_P3_MODE, 32'h0202);
    lvl3 <= 16'h0200;
    en <= 6'b010001;
    settle;
    check({conf, rx0, irq7, rx2, irq8}, 5'b10011);
    // port data on pins 1 and 9 must not reach the pins in alternate mode
    apb(1, `PM_OFS_P3_DATA, 32'h0203);
    apb(1, `PM_OFS_P3_DIR, 32'hFFFE);
    en <= 6'b010000;
    settle;
    check(conf, 0);
    check({out3, oe3}, 32'h00010001);
    @(posedge mclk) en <= 6'b000100;
    settle;
    check(conf, 0);
    @(posedge mclk) en <= 6'b100100;
    settle;
    check(conf, 1);
    apb(1, `PM_OFS_P3_MODE, 0);
    settle;
    check({rx0, irq7, rx2, irq8}, 4'b1010);
    $display("test share done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    error_cnt++;
    give_verdict;
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_port;
    t_debug;
    t_share;
    give_verdict;
  end
endmodule
bind port_alt_function_select pin_mux_sva #(.PORT_W(PORT_W)) i_sva (.mclk(mclk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .port0_pin_in(port0_pin_in), .port0_pin_out(port0_pin_out), .port0_pin_oe(port0_pin_oe),
  .port3_pin_in(port3_pin_in), .irq7_rising_enable(irq7_rising_enable),
  .irq7_falling_enable(irq7_falling_enable), .uart0_receive_enable(uart0_receive_enable),
  .debug_unit_reset_in(debug_unit_reset_in), .debug_pulldown_on(debug_pulldown_on),
  .ext_irq2_in(ext_irq2_in), .ext_irq7_in(ext_irq7_in), .ext_irq8_in(ext_irq8_in),
  .uart0_receive_in(uart0_receive_in), .uart2_receive_in(uart2_receive_in),
  .share_conflict(share_conflict));
